// >>> verilog/edgrt_pkg.sv
// Purpose: Shared constants and types for the edge and runtime counter block
// Assumes: 10 MHz system clock, one clock domain
// Notes: All figures are named once here

package edgrt_pkg;
    // ====================================================
    // Sizes
    localparam int NUM_PINS = 31;
    localparam int CNT_W = 32;
    localparam int SEL_W = 5;
    // ====================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYC = CLK_HZ / MS_PER_S;
    localparam logic [13:0] TICK_LAST = 14'(TICK_CYC - 1);
    localparam int MAX_EDGE_HZ = 10_000;
    // ====================================================
    // Field limits
    localparam logic [9:0] MS_LAST = 10'h3e7;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    // ====================================================
    // Runtime field selector for load commands
    typedef enum logic [2:0] {
        EDGRT_F_MS,
        EDGRT_F_SEC,
        EDGRT_F_MIN,
        EDGRT_F_HOUR,
        EDGRT_F_DAY,
        EDGRT_F_TOTAL
    } edgrt_field_t;
endpackage

// >>> verilog/edgrt_tick_if.sv
// Purpose: Carries the millisecond tick between the tick divider and the top
// Assumes: Single clock
// Notes: Source drives tick, top consumes it
`timescale 1ns/1ps

interface edgrt_tick_if;
    logic tick; // One-cycle pulse each millisecond
    logic clear; // Restart divider phase
    modport source (output tick, input clear);
    modport sink (input tick, output clear);
endinterface

// >>> verilog/edgrt_tick_gen.sv
// Purpose: Divides the system clock to a one millisecond tick
// Assumes: Synchronous active-low reset
// Notes: Clear restarts the divider so a runtime reset starts a full interval
`timescale 1ns/1ps

module edgrt_tick_gen (
    input wire logic clk_in,
    input wire logic rst_b_in,
    edgrt_tick_if.source tk
);
    // ====================================================
    // State
    typedef struct packed {
        logic [13:0] div; // Cycle count within a millisecond
        logic tick; // Registered tick pulse
    } edgrt_tick_st_t;
    edgrt_tick_st_t st_q, st_d;

    // Next-state logic
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (tk.clear) begin
            st_d.div = '0;
        end else if (st_q.div == edgrt_pkg::TICK_LAST) begin
            st_d.div = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.div = st_q.div + 14'h1;
        end
    end

    // Register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tk.tick = st_q.tick;

    // Tick is followed by at least eight cycles without a tick
    property p_tick_gap;
        @(posedge clk_in) disable iff (!rst_b_in)
        st_q.tick && !tk.clear |=> !st_q.tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too close");
endmodule

// >>> verilog/edgrt_top.sv
// Purpose: Per-pin edge counters and cascaded runtime counters
// Assumes: Inputs synchronous to clk_in; commands are one-cycle strobes
// Notes: Runtime counting starts when loading_screen_in is first seen high
//
// Summary of operation
// - Each pin counter is unsigned 32 bits
// - Configured pin edge increments counter by one
// - Pin reset clears only selected counter
// - Pin load writes value, counting continues
// - All pin counters readable at any time
// - Edges counted at up to 10 kHz
// - Thirty-one counters, counter n on pin n
// - Runtime reset zeroes all fields, resumes counting
// - Runtime counters free-run, no calendar dependence
// - Runtime starts from zero at loading screen
// - Cascaded ms, s, min, h fields wrap
// - Day field counts days, 32 bits
// - Total field counts milliseconds, 32 bits
// - Load to runtime field overwrites it
// - Each runtime field pulses on wrap
`timescale 1ns/1ps

module edgrt_top #(
    parameter int NUM_PINS = edgrt_pkg::NUM_PINS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [NUM_PINS-1:0] pin_level_in, // Digital input pins
    input wire logic [NUM_PINS-1:0] pin_sense_en_in, // Pin set up for edge sensing
    input wire logic [NUM_PINS-1:0] pin_fall_sel_in, // 1 = falling, 0 = rising
    input wire logic pin_reset_in, // Clear selected pin counter
    input wire logic pin_load_in, // Load selected pin counter
    input wire logic [edgrt_pkg::SEL_W-1:0] pin_sel_in, // Pin counter selector
    input wire logic [31:0] load_value_in, // Value for any load
    input wire logic loading_screen_in, // Module reached loading screen
    input wire logic run_reset_in, // Zero all runtime fields
    input wire logic run_load_in, // Load one runtime field
    input wire logic [2:0] run_field_sel_in, // Runtime field selector
    output logic [NUM_PINS*32-1:0] pin_edge_count_out, // All pin counters
    output logic [9:0] run_millisecond_field_out,
    output logic [5:0] run_second_field_out,
    output logic [5:0] run_minute_field_out,
    output logic [4:0] run_hour_field_out,
    output logic [31:0] run_day_field_out,
    output logic [31:0] run_total_milliseconds_out,
    output logic [5:0] run_wrap_out // Wrap pulses: ms, s, min, h, day, total
);
    // ====================================================
    // Types and state
    typedef enum logic [0:0] {
        EDGRT_IDLE,
        EDGRT_RUN
    } edgrt_run_state_t;

    typedef struct packed {
        logic [NUM_PINS-1:0][31:0] pin_cnt; // Pin edge counters
        logic [NUM_PINS-1:0] pin_prev; // Last sampled pin level
        edgrt_run_state_t run_st; // Runtime started or not
        logic [9:0] ms; // Millisecond field
        logic [5:0] sec; // Second field
        logic [5:0] min; // Minute field
        logic [4:0] hour; // Hour field
        logic [31:0] day; // Day field
        logic [31:0] total; // Total milliseconds
        logic [5:0] wrap; // Registered wrap pulses
    } edgrt_state_t;

    edgrt_state_t st_q, st_d;
    edgrt_tick_if tk ();
    logic [NUM_PINS-1:0] edge_hit; // Configured edge seen this cycle

    // Millisecond divider
    edgrt_tick_gen u_tick (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .tk(tk)
    );

    // Check whether a field is the one addressed by a load
    function automatic logic field_hit(input logic ld, input logic [2:0] sel,
                                       input edgrt_pkg::edgrt_field_t f);
        field_hit = ld && (sel == f);
    endfunction

    // ====================================================
    // Edge detection per pin
    // Restart divider on runtime reset or before counting starts
    assign tk.clear = run_reset_in || (st_q.run_st == EDGRT_IDLE);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_edge
            // Rising or falling as selected, only while sensing is enabled
            assign edge_hit[gi] = pin_sense_en_in[gi] &&
                (pin_fall_sel_in[gi] ? (st_q.pin_prev[gi] && !pin_level_in[gi]) :
                                       (!st_q.pin_prev[gi] && pin_level_in[gi]));
            // Counter n sits at slice n
            assign pin_edge_count_out[gi*32 +: 32] = st_q.pin_cnt[gi];
        end
    endgenerate

    // ====================================================
    // Next-state logic
    always_comb begin
        logic cy_ms;
        logic cy_sec;
        logic cy_min;
        logic cy_hour;
        cy_ms = 1'b0;
        cy_sec = 1'b0;
        cy_min = 1'b0;
        cy_hour = 1'b0;
        st_d = st_q;
        st_d.pin_prev = pin_level_in;
        st_d.wrap = '0;

        // Pin counters: command for selected pin wins over an edge
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_reset_in && (pin_sel_in == 5'(i))) begin
                st_d.pin_cnt[i] = edgrt_pkg::CNT_RESET;
            end else if (pin_load_in && (pin_sel_in == 5'(i))) begin
                st_d.pin_cnt[i] = load_value_in;
            end else if (edge_hit[i]) begin
                st_d.pin_cnt[i] = st_q.pin_cnt[i] + 32'h1;
            end
        end

        // Runtime counters
        case (st_q.run_st)
            EDGRT_IDLE: begin
                // Hold at zero until the loading screen shows
                if (loading_screen_in) begin
                    st_d.run_st = EDGRT_RUN;
                end
            end
            EDGRT_RUN: begin
                if (tk.tick) begin
                    st_d.total = st_q.total + 32'h1;
                    st_d.wrap[5] = (st_q.total == 32'hffff_ffff);
                    cy_ms = (st_q.ms == edgrt_pkg::MS_LAST);
                    st_d.ms = cy_ms ? 10'h0 : st_q.ms + 10'h1;
                    if (cy_ms) begin
                        cy_sec = (st_q.sec == edgrt_pkg::SEC_LAST);
                        st_d.sec = cy_sec ? 6'h0 : st_q.sec + 6'h1;
                    end
                    if (cy_sec) begin
                        cy_min = (st_q.min == edgrt_pkg::MIN_LAST);
                        st_d.min = cy_min ? 6'h0 : st_q.min + 6'h1;
                    end
                    if (cy_min) begin
                        cy_hour = (st_q.hour == edgrt_pkg::HOUR_LAST);
                        st_d.hour = cy_hour ? 5'h0 : st_q.hour + 5'h1;
                    end
                    if (cy_hour) begin
                        st_d.day = st_q.day + 32'h1;
                        st_d.wrap[4] = (st_q.day == 32'hffff_ffff);
                    end
                    st_d.wrap[3:0] = {cy_hour, cy_min, cy_sec, cy_ms};
                end
            end
            default: begin
                st_d.run_st = EDGRT_IDLE;
            end
        endcase

        // Field loads overwrite after counting
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_MS)) begin
            st_d.ms = load_value_in[9:0];
        end
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_SEC)) begin
            st_d.sec = load_value_in[5:0];
        end
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_MIN)) begin
            st_d.min = load_value_in[5:0];
        end
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_HOUR)) begin
            st_d.hour = load_value_in[4:0];
        end
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_DAY)) begin
            st_d.day = load_value_in;
        end
        if (field_hit(run_load_in, run_field_sel_in, edgrt_pkg::EDGRT_F_TOTAL)) begin
            st_d.total = load_value_in;
        end

        // Global runtime reset wins over counting and field loads
        if (run_reset_in) begin
            st_d.ms = '0;
            st_d.sec = '0;
            st_d.min = '0;
            st_d.hour = '0;
            st_d.day = '0;
            st_d.total = '0;
        end
    end

    // ====================================================
    // Register: free-running, no configuration needed
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from flip-flops
    assign run_millisecond_field_out = st_q.ms;
    assign run_second_field_out = st_q.sec;
    assign run_minute_field_out = st_q.min;
    assign run_hour_field_out = st_q.hour;
    assign run_day_field_out = st_q.day;
    assign run_total_milliseconds_out = st_q.total;
    assign run_wrap_out = st_q.wrap;

    // ====================================================
    // Assertions
    property p_edge_inc;
        @(posedge clk_in) disable iff (!rst_b_in)
        edge_hit[0] && !pin_reset_in && !pin_load_in |=>
            st_q.pin_cnt[0] == $past(st_q.pin_cnt[0]) + 32'h1;
    endproperty
    a_edge_inc: assert property (p_edge_inc) else $error("edge not counted");

    // Reset of one counter leaves a far counter counting on
    property p_pin_reset;
        @(posedge clk_in) disable iff (!rst_b_in)
        pin_reset_in && pin_sel_in == 5'h0 |=> st_q.pin_cnt[0] == 32'h0 &&
            st_q.pin_cnt[30] == $past(st_q.pin_cnt[30]) + 32'($past(edge_hit[30]));
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset wrong");

    property p_pin_load;
        @(posedge clk_in) disable iff (!rst_b_in)
        pin_load_in && !pin_reset_in && pin_sel_in == 5'h7 |=>
            st_q.pin_cnt[7] == $past(load_value_in);
    endproperty
    a_pin_load: assert property (p_pin_load) else $error("pin load wrong");

    // A pin without edge sensing never counts, even while it toggles
    property p_no_sense;
        @(posedge clk_in) disable iff (!rst_b_in)
        !pin_sense_en_in[5] && !pin_reset_in && !pin_load_in |=> $stable(st_q.pin_cnt[5]);
    endproperty
    a_no_sense: assert property (p_no_sense) else $error("count without sense");

    // Runtime reset clears every field together
    property p_run_reset;
        @(posedge clk_in) disable iff (!rst_b_in)
        run_reset_in |=> st_q.ms == 10'h0 && st_q.sec == 6'h0 && st_q.min == 6'h0 &&
            st_q.hour == 5'h0 && st_q.day == 32'h0 && st_q.total == 32'h0;
    endproperty
    a_run_reset: assert property (p_run_reset) else $error("runtime reset wrong");

    // Total holds still until the loading screen starts the runtime
    property p_idle_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        st_q.run_st == EDGRT_IDLE && !run_load_in && !run_reset_in |=>
            st_q.total == $past(st_q.total);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("counted before start");

    property p_ms_range;
        @(posedge clk_in) disable iff (!rst_b_in)
        $past(st_q.ms) == edgrt_pkg::MS_LAST && $past(tk.tick) && !$past(run_load_in) &&
            st_q.run_st == EDGRT_RUN |-> st_q.ms == 10'h0 && st_q.wrap[0];
    endproperty
    a_ms_range: assert property (p_ms_range) else $error("ms wrap wrong");

    property p_total_step;
        @(posedge clk_in) disable iff (!rst_b_in)
        st_q.run_st == EDGRT_RUN && tk.tick && !run_reset_in && !run_load_in |=>
            st_q.total == $past(st_q.total) + 32'h1;
    endproperty
    a_total_step: assert property (p_total_step) else $error("total not stepped");

    property p_hour_max;
        @(posedge clk_in) disable iff (!rst_b_in)
        !run_load_in |=> st_q.hour <= edgrt_pkg::HOUR_LAST || $past(st_q.hour) > 5'h17;
    endproperty
    a_hour_max: assert property (p_hour_max) else $error("hour out of range");

    // Last millisecond of a day steps the day field
    property p_day_step;
        @(posedge clk_in) disable iff (!rst_b_in)
        st_q.run_st == EDGRT_RUN && tk.tick && st_q.ms == edgrt_pkg::MS_LAST &&
            st_q.sec == edgrt_pkg::SEC_LAST && st_q.min == edgrt_pkg::MIN_LAST &&
            st_q.hour == edgrt_pkg::HOUR_LAST && !run_reset_in && !run_load_in |=>
            st_q.day == $past(st_q.day) + 32'h1 && st_q.hour == 5'h0;
    endproperty
    a_day_step: assert property (p_day_step) else $error("day not stepped");

    // Counter at its top value rolls over to zero
    property p_pin_wrap;
        @(posedge clk_in) disable iff (!rst_b_in)
        edge_hit[7] && !pin_reset_in && !pin_load_in && st_q.pin_cnt[7] == 32'hffff_ffff |=>
            st_q.pin_cnt[7] == 32'h0;
    endproperty
    a_pin_wrap: assert property (p_pin_wrap) else $error("pin count saturated");

    // Load of the second field overwrites it
    property p_sec_load;
        @(posedge clk_in) disable iff (!rst_b_in)
        run_load_in && run_field_sel_in == 3'h1 && !run_reset_in |=>
            st_q.sec == $past(load_value_in[5:0]);
    endproperty
    a_sec_load: assert property (p_sec_load) else $error("field load wrong");

    // Main scenarios reached
    c_edge: cover property (@(posedge clk_in) disable iff (!rst_b_in) edge_hit[0]);
    c_sec_wrap: cover property (@(posedge clk_in) disable iff (!rst_b_in) st_q.wrap[1]);
    c_load: cover property (@(posedge clk_in) disable iff (!rst_b_in) run_load_in);
    c_total_wrap: cover property (@(posedge clk_in) disable iff (!rst_b_in) st_q.wrap[5]);
    c_run_reset: cover property (@(posedge clk_in) disable iff (!rst_b_in) run_reset_in);
endmodule

// >>> tb/earc_pin_model.sv
// Purpose: Switch-like driver for the digital input pins
// Assumes: Pin levels change only at the falling clock edge
// Notes: Each flip is followed by two quiet cycles
`timescale 1ns/1ps

module earc_pin_model (
    input wire logic clk_in,
    output logic [30:0] pin_level_out
);
    // ==========================================
    // Pin levels
    // All pins rest low from time zero
    initial begin
        pin_level_out = 31'h0;
    end

    // Flip one pin, then hold it so edges stay well apart
    task automatic flip(input int idx);
        @(negedge clk_in);
        pin_level_out[idx] = ~pin_level_out[idx];
        repeat (2) @(negedge clk_in);
    endtask
endmodule

// >>> tb/edge_and_runtime_counters_test.sv
// Purpose: Self-checking bench for the edge and runtime counters
// Assumes: Inputs change at the falling edge; outputs sampled there too
// Notes: Runtime checks wait on real millisecond ticks of 10000 cycles
`timescale 1ns/1ps

module edge_and_runtime_counters_test;
    // ==========================================
    // Signals
    logic clk_in;
    logic rst_b_in;
    logic [30:0] pin_level; // From the pin model
    logic [30:0] sense_en; // Edge sensing set up per pin
    logic [30:0] fall_sel; // Falling edge selection per pin
    logic [3:0] ops; // Strobes: pin load, pin reset, run load, run reset
    logic [4:0] pin_sel;
    logic [2:0] field_sel;
    logic [31:0] load_value;
    logic loading_screen;
    logic [991:0] counts;
    logic [9:0] ms;
    logic [5:0] sec;
    logic [5:0] mins;
    logic [4:0] hour;
    logic [31:0] day;
    logic [31:0] total;
    logic [5:0] wrap;
    int error_cnt = 0;
    int n_compared = 0;
    int n;

    // ==========================================
    // Design and pin model
    edgrt_top DUT (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .pin_level_in(pin_level),
        .pin_sense_en_in(sense_en), .pin_fall_sel_in(fall_sel),
        .pin_reset_in(ops[1]), .pin_load_in(ops[0]), .pin_sel_in(pin_sel),
        .load_value_in(load_value), .loading_screen_in(loading_screen),
        .run_reset_in(ops[3]), .run_load_in(ops[2]), .run_field_sel_in(field_sel),
        .pin_edge_count_out(counts), .run_millisecond_field_out(ms),
        .run_second_field_out(sec), .run_minute_field_out(mins),
        .run_hour_field_out(hour), .run_day_field_out(day),
        .run_total_milliseconds_out(total), .run_wrap_out(wrap)
    );
    earc_pin_model PINS (.clk_in(clk_in), .pin_level_out(pin_level));

    // ==========================================
    // Helpers
    // Prints the verdict and ends the run
    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pulses command strobes for one cycle
    task automatic cmd(input logic [3:0] op, input logic [4:0] s, input logic [2:0] f,
                       input logic [31:0] v);
        @(negedge clk_in);
        ops = op;
        pin_sel = s;
        field_sel = f;
        load_value = v;
        @(negedge clk_in);
        ops = 4'h0;
    endtask

    // Waits, bounded, for the millisecond field to move; n counts cycles
    task automatic step(output int cyc);
        logic [9:0] old;
        old = ms;
        cyc = 0;
        do begin
            @(negedge clk_in);
            cyc++;
        end while (ms === old && cyc < 10100);
        if (cyc >= 10100) begin
            error_cnt++;
            $display("wrong value at %0t: millisecond field stuck", $time);
            summarize();
        end
    endtask

    // ==========================================
    // Scenarios
    // Edges on enabled pins count by polarity; a disabled pin never counts
    task automatic pin_edges();
        sense_en = 31'h4000_0081;
        fall_sel = 31'h4000_0000;
        repeat (4) PINS.flip(0);
        repeat (4) PINS.flip(30);
        repeat (2) PINS.flip(5);
        chk(counts[31:0], 32'h2);
        chk(counts[991:960], 32'h2);
        chk(counts[191:160], 32'h0);
    endtask

    // Load at the top value wraps on the next edge; reset hits one counter
    task automatic pin_load_reset();
        cmd(4'h1, 5'h07, 3'h0, 32'hffff_ffff);
        chk(counts[255:224], 32'hffff_ffff);
        PINS.flip(7);
        chk(counts[255:224], 32'h0);
        chk(counts[31:0], 32'h2);
        cmd(4'h2, 5'h00, 3'h0, 32'h0);
        chk(counts[31:0], 32'h0);
        chk(counts[991:960], 32'h2);
    endtask

    // Runtime waits for the loading screen, then ticks every 10000 cycles
    task automatic run_start();
        repeat (20) @(negedge clk_in);
        chk(32'(ms), 32'h0);
        loading_screen = 1'b1;
        step(n);
        chk(32'(ms), 32'h1);
        step(n);
        chk(n, edgrt_pkg::TICK_CYC);
        chk(total, 32'h2);
    endtask

    // Loaded ms, s, min, h and total fields roll over together, day steps to its top, with the proper wrap pulses
    task automatic run_cascade();
        logic [31:0] vals [6];
        vals = '{32'h3e7, 32'h3b, 32'h3b, 32'h17, 32'hffff_fffe, 32'hffff_ffff};
        step(n);
        for (int f = 0; f < 6; f++) begin
            cmd(4'h4, 5'h00, 3'(f), vals[f]);
        end
        chk(32'(sec), 32'h3b);
        step(n);
        chk({ms, sec, mins, hour}, 32'h0);
        chk(day, 32'hffff_ffff);
        chk(total, 32'h0);
        chk(32'(wrap), 32'h2f);
        @(negedge clk_in);
        chk(32'(wrap), 32'h0);
    endtask

    // Runtime reset zeroes every field and counting resumes
    task automatic run_clear();
        cmd(4'h4, 5'h00, 3'h2, 32'h7);
        chk(32'(mins), 32'h7);
        cmd(4'h8, 5'h00, 3'h0, 32'h0);
        chk({ms, sec, mins, hour}, 32'h0);
        chk(day | total, 32'h0);
        step(n);
        chk(32'(n > 9998 && n < 10003), 32'h1);
        chk(total, 32'h1);
    endtask

    // ==========================================
    // Clock, reset and main sequence
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        rst_b_in = 1'b0;
        sense_en = 31'h0;
        fall_sel = 31'h0;
        ops = 4'h0;
        pin_sel = 5'h00;
        field_sel = 3'h0;
        load_value = 32'h0;
        loading_screen = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
        chk(counts[31:0] | total, 32'h0);
        pin_edges();
        pin_load_reset();
        run_start();
        run_cascade();
        run_clear();
        summarize();
    end
endmodule
